// *** design/grlc_pkg.sv ***
// shared constants for the bus remote/local control block
package grlc_pkg;
    // register byte offsets on the apb slave
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_SRE = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_STB = 12'h00c;

    // control register layout and primary address limits
    localparam int CTRL_ADDR_LSB = 0;
    localparam int CTRL_ADDR_MSB = 4;
    localparam int CTRL_TRIG_BIT = 8;
    localparam logic [4:0] ADDR_RESET = 5'h10;
    localparam logic [4:0] ADDR_MAX = 5'h1e;

    // status register bit positions
    localparam int ST_REMOTE = 0;
    localparam int ST_LOCK = 1;
    localparam int ST_TALK = 2;
    localparam int ST_LISTEN = 3;
    localparam int ST_SPOLL = 4;
    localparam int ST_SRQ = 5;

    // status byte bit positions
    localparam int STB_MAV_BIT = 4;
    localparam int STB_RQS_BIT = 6;
    localparam logic [7:0] SRE_RESET = 8'h00;
    localparam logic [7:0] STB_RESET = 8'h00;

    // interface messages, low seven bits of a byte sent with attention
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK = 2'h2;
    localparam logic [4:0] ADDR_UNADDR = 5'h1f;

    // front panel key codes
    localparam logic [3:0] KEY_POWER = 4'h0;
    localparam logic [3:0] KEY_LOCAL = 4'h1;

    // remote/local state
    typedef enum logic [0:0] {RL_LOCAL, RL_REMOTE} grlc_rl_type;
endpackage

// *** design/grlc_sync.sv ***
// two flip-flop synchroniser for one asynchronous pin
`timescale 1ns/10ps
module grlc_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    // first stage is read only by the second stage
    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign pin_sync = sync_reg;
endmodule

// *** design/grlc_top.sv ***
// bus remote/local control: addressing, clears, trigger, service request
//
// How it works
// - primary address resets to 16; writes above 30 are ignored
// - service request raised while message available and its enable bit set
// - remote entered only when addressed to listen with remote enable true
// - talker role works in both local and remote states
// - in remote only power and local keys act; local key returns local
// - interface clear drops talk and listen, leaves settings untouched
// - lockout blocks all keys but power, local too, until go-to-local or remote enable drops
// - addressed go-to-local leaves remote and restores the front panel
// - device clear pulses a clear of buffers, queue and deferred commands
// - universal device clear acts whatever the addressed state
// - selective device clear acts only while addressed to listen
// - group trigger fires only when bus trigger is the selected source
// - status byte returned on serial poll at any time
// - remote indicator lit in remote; local key clears it, restores display
`timescale 1ns/10ps
module grlc_top #(
    parameter int ADDR_W = 12
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ifc_b,
    input wire logic ren_b,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic mav_in,
    input wire logic key_valid,
    input wire logic [3:0] key_code,
    output logic key_fwd_valid,
    output logic [3:0] key_fwd_code,
    output logic talk_active,
    output logic listen_active,
    output logic remote_ind,
    output logic lockout,
    output logic spoll_active,
    output logic [7:0] spoll_byte,
    output logic srq_out,
    output logic dev_clear,
    output logic trig_out,
    output logic display_restore
);
    logic ifc_s_b;
    logic ren_s_b;

    // pins arrive from the cable, so both pass a synchroniser
    grlc_sync #(.RESET_VAL(1'b1)) u_sync_ifc (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(ifc_b),
        .pin_sync(ifc_s_b)
    );
    grlc_sync #(.RESET_VAL(1'b1)) u_sync_ren (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(ren_b),
        .pin_sync(ren_s_b)
    );

    logic ifc_act;
    logic ren_act;
    logic cmd_ok;
    logic mla_cmd;
    logic mta_cmd;
    logic ota_cmd;
    logic unl_cmd;
    logic unt_cmd;
    logic gtl_cmd;
    logic llo_cmd;
    logic dcl_cmd;
    logic sdc_cmd;
    logic get_cmd;
    logic spe_cmd;
    logic spd_cmd;
    logic key_local;
    logic key_power;

    logic [4:0] addr_reg, addr_next;
    logic trig_bus_reg, trig_bus_next;
    logic [7:0] sre_reg, sre_next;
    logic [7:0] stb_sw_reg, stb_sw_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;

    grlc_pkg::grlc_rl_type rl_reg, rl_next;
    logic lockout_reg, lockout_next;
    logic remote_ind_reg, remote_ind_next;
    logic talk_reg, talk_next;
    logic listen_reg, listen_next;
    logic spoll_reg, spoll_next;
    logic [7:0] spoll_byte_reg, spoll_byte_next;
    logic srq_reg, srq_next;
    logic dev_clear_reg, dev_clear_next;
    logic trig_reg, trig_next;
    logic restore_reg, restore_next;
    logic key_fwd_valid_reg, key_fwd_valid_next;
    logic [3:0] key_fwd_code_reg, key_fwd_code_next;
    logic [7:0] stb_live;

    // message decode; nothing is taken while interface clear is held
    always_comb begin
        ifc_act = !ifc_s_b;
        ren_act = !ren_s_b;
        cmd_ok = cmd_valid && !ifc_act;
        mla_cmd = cmd_ok && cmd_byte[6:5] == grlc_pkg::GRP_LISTEN
            && cmd_byte[4:0] == addr_reg;
        mta_cmd = cmd_ok && cmd_byte[6:5] == grlc_pkg::GRP_TALK
            && cmd_byte[4:0] == addr_reg;
        ota_cmd = cmd_ok && cmd_byte[6:5] == grlc_pkg::GRP_TALK
            && cmd_byte[4:0] != addr_reg && cmd_byte[4:0] != grlc_pkg::ADDR_UNADDR;
        unl_cmd = cmd_ok && cmd_byte[6:5] == grlc_pkg::GRP_LISTEN
            && cmd_byte[4:0] == grlc_pkg::ADDR_UNADDR;
        unt_cmd = cmd_ok && cmd_byte[6:5] == grlc_pkg::GRP_TALK
            && cmd_byte[4:0] == grlc_pkg::ADDR_UNADDR;
        gtl_cmd = cmd_ok && cmd_byte[6:0] == grlc_pkg::CMD_GTL;
        llo_cmd = cmd_ok && cmd_byte[6:0] == grlc_pkg::CMD_LLO;
        dcl_cmd = cmd_ok && cmd_byte[6:0] == grlc_pkg::CMD_DCL;
        sdc_cmd = cmd_ok && cmd_byte[6:0] == grlc_pkg::CMD_SDC;
        get_cmd = cmd_ok && cmd_byte[6:0] == grlc_pkg::CMD_GET;
        spe_cmd = cmd_ok && cmd_byte[6:0] == grlc_pkg::CMD_SPE;
        spd_cmd = cmd_ok && cmd_byte[6:0] == grlc_pkg::CMD_SPD;
        key_local = key_valid && key_code == grlc_pkg::KEY_LOCAL;
        key_power = key_valid && key_code == grlc_pkg::KEY_POWER;
    end

    // live status byte: software bits plus hardware message-available and rqs
    always_comb begin
        stb_live = stb_sw_reg;
        stb_live[grlc_pkg::STB_MAV_BIT] = mav_in;
        stb_live[grlc_pkg::STB_RQS_BIT] = srq_reg;
    end

    // apb slave: zero wait states, data and error prepared in the setup cycle
    always_comb begin
        addr_next = addr_reg;
        trig_bus_next = trig_bus_reg;
        sre_next = sre_reg;
        stb_sw_next = stb_sw_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        pready_next = 1'b1;
        if (psel && !penable) begin
            prdata_next = 32'h0000_0000;
            unique case (paddr[11:0])
                grlc_pkg::OFF_CTRL: begin
                    prdata_next[grlc_pkg::CTRL_ADDR_MSB:grlc_pkg::CTRL_ADDR_LSB] = addr_reg;
                    prdata_next[grlc_pkg::CTRL_TRIG_BIT] = trig_bus_reg;
                end
                grlc_pkg::OFF_SRE: prdata_next[7:0] = sre_reg;
                grlc_pkg::OFF_STATUS: begin
                    prdata_next[grlc_pkg::ST_REMOTE] = remote_ind_reg;
                    prdata_next[grlc_pkg::ST_LOCK] = lockout_reg;
                    prdata_next[grlc_pkg::ST_TALK] = talk_reg;
                    prdata_next[grlc_pkg::ST_LISTEN] = listen_reg;
                    prdata_next[grlc_pkg::ST_SPOLL] = spoll_reg;
                    prdata_next[grlc_pkg::ST_SRQ] = srq_reg;
                end
                grlc_pkg::OFF_STB: prdata_next[7:0] = stb_live;
                default: pslverr_next = 1'b1;
            endcase
        end
        // writes land in the access cycle; an out-of-range address is kept out
        if (psel && penable && pwrite) begin
            unique case (paddr[11:0])
                grlc_pkg::OFF_CTRL: begin
                    if (pwdata[grlc_pkg::CTRL_ADDR_MSB:grlc_pkg::CTRL_ADDR_LSB]
                        <= grlc_pkg::ADDR_MAX) begin
                        addr_next = pwdata[grlc_pkg::CTRL_ADDR_MSB:grlc_pkg::CTRL_ADDR_LSB];
                    end
                    trig_bus_next = pwdata[grlc_pkg::CTRL_TRIG_BIT];
                end
                grlc_pkg::OFF_SRE: sre_next = pwdata[7:0];
                grlc_pkg::OFF_STB: stb_sw_next = pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            addr_reg <= grlc_pkg::ADDR_RESET;
            trig_bus_reg <= 1'b0;
            sre_reg <= grlc_pkg::SRE_RESET;
            stb_sw_reg <= grlc_pkg::STB_RESET;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            addr_reg <= addr_next;
            trig_bus_reg <= trig_bus_next;
            sre_reg <= sre_next;
            stb_sw_reg <= stb_sw_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // addressing, remote/local, lockout, clears and trigger
    always_comb begin
        rl_next = rl_reg;
        lockout_next = lockout_reg;
        talk_next = talk_reg;
        listen_next = listen_reg;
        spoll_next = spoll_reg;
        dev_clear_next = 1'b0;
        trig_next = 1'b0;
        restore_next = 1'b0;
        key_fwd_valid_next = 1'b0;
        key_fwd_code_next = key_fwd_code_reg;
        if (ifc_act) begin
            // only the addressed state goes; settings and registers stay
            talk_next = 1'b0;
            listen_next = 1'b0;
            spoll_next = 1'b0;
        end
        if (mla_cmd || unl_cmd) begin
            listen_next = mla_cmd;
        end
        if (mta_cmd || ota_cmd || unt_cmd) begin
            talk_next = mta_cmd;
        end
        if (spe_cmd || spd_cmd) begin
            spoll_next = spe_cmd;
        end
        if (llo_cmd) begin
            lockout_next = 1'b1;
        end
        dev_clear_next = dcl_cmd || (sdc_cmd && listen_reg);
        trig_next = get_cmd && listen_reg && trig_bus_reg;
        unique case (rl_reg)
            grlc_pkg::RL_LOCAL: begin
                if (ren_act && mla_cmd) begin
                    rl_next = grlc_pkg::RL_REMOTE;
                end
            end
            grlc_pkg::RL_REMOTE: begin
                if (gtl_cmd && listen_reg) begin
                    rl_next = grlc_pkg::RL_LOCAL;
                end else if (key_local && !lockout_reg) begin
                    rl_next = grlc_pkg::RL_LOCAL;
                    restore_next = 1'b1;
                end
            end
        endcase
        if (gtl_cmd && listen_reg) begin
            lockout_next = 1'b0;
        end
        // dropping remote enable returns everything to local
        if (!ren_act) begin
            rl_next = grlc_pkg::RL_LOCAL;
            lockout_next = 1'b0;
        end
        // power always passes; others only in local with no lockout
        if (key_power || (key_valid && rl_reg == grlc_pkg::RL_LOCAL && !lockout_reg)) begin
            key_fwd_valid_next = 1'b1;
            key_fwd_code_next = key_code;
        end
    end

    // outputs registered from next values so each port is a flop
    always_comb begin
        remote_ind_next = rl_next == grlc_pkg::RL_REMOTE;
        srq_next = |(stb_live & sre_reg & ~(8'h01 << grlc_pkg::STB_RQS_BIT));
        spoll_byte_next = stb_live;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rl_reg <= grlc_pkg::RL_LOCAL;
            lockout_reg <= 1'b0;
            remote_ind_reg <= 1'b0;
            talk_reg <= 1'b0;
            listen_reg <= 1'b0;
            spoll_reg <= 1'b0;
            spoll_byte_reg <= 8'h00;
            srq_reg <= 1'b0;
            dev_clear_reg <= 1'b0;
            trig_reg <= 1'b0;
            restore_reg <= 1'b0;
            key_fwd_valid_reg <= 1'b0;
            key_fwd_code_reg <= 4'h0;
        end else begin
            rl_reg <= rl_next;
            lockout_reg <= lockout_next;
            remote_ind_reg <= remote_ind_next;
            talk_reg <= talk_next;
            listen_reg <= listen_next;
            spoll_reg <= spoll_next;
            spoll_byte_reg <= spoll_byte_next;
            srq_reg <= srq_next;
            dev_clear_reg <= dev_clear_next;
            trig_reg <= trig_next;
            restore_reg <= restore_next;
            key_fwd_valid_reg <= key_fwd_valid_next;
            key_fwd_code_reg <= key_fwd_code_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign key_fwd_valid = key_fwd_valid_reg;
    assign key_fwd_code = key_fwd_code_reg;
    assign talk_active = talk_reg;
    assign listen_active = listen_reg;
    assign remote_ind = remote_ind_reg;
    assign lockout = lockout_reg;
    assign spoll_active = spoll_reg;
    assign spoll_byte = spoll_byte_reg;
    assign srq_out = srq_reg;
    assign dev_clear = dev_clear_reg;
    assign trig_out = trig_reg;
    assign display_restore = restore_reg;

    // checks on the control behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence local_key_in_remote;
        remote_ind_reg && key_local && !lockout_reg && ren_act && !cmd_valid;
    endsequence
    sequence listen_with_ren;
        ren_act && mla_cmd;
    endsequence

    addr_reset_a: assert property (!$past(rst_b) |-> addr_reg == grlc_pkg::ADDR_RESET)
        else $error("primary address not at reset value");
    addr_range_a: assert property (addr_reg <= grlc_pkg::ADDR_MAX)
        else $error("primary address out of range");
    listen_match_a: assert property (mla_cmd |=> listen_reg)
        else $error("own listen address not taken");
    srq_mav_a: assert property (mav_in && sre_reg[grlc_pkg::STB_MAV_BIT] |=> srq_out)
        else $error("no service request with message available");
    remote_entry_a: assert property ($rose(remote_ind_reg) |-> $past(ren_act && mla_cmd))
        else $error("remote entered without listen address");
    remote_go_a: assert property (listen_with_ren |=> remote_ind_reg)
        else $error("remote not entered");
    talk_any_a: assert property (mta_cmd |=> talk_active)
        else $error("talk address not taken");
    key_block_a: assert property (remote_ind_reg && key_valid && !key_power
        |=> !key_fwd_valid)
        else $error("key passed in remote");
    local_key_a: assert property (local_key_in_remote |=> !remote_ind_reg
        && display_restore ##1 !display_restore)
        else $error("local key did not return local");
    ifc_clear_a: assert property (ifc_act |=> !talk_reg && !listen_reg)
        else $error("interface clear left addressed state");
    lockout_hold_a: assert property (lockout_reg && remote_ind_reg && ren_act
        && key_local && !cmd_valid |=> remote_ind_reg)
        else $error("local key acted under lockout");
    gtl_local_a: assert property (gtl_cmd && listen_reg |=> !remote_ind_reg && !lockout_reg)
        else $error("go-to-local ignored");
    // a second clear byte right behind the first may legally stretch the pulse
    dcl_any_a: assert property (dcl_cmd |=> dev_clear
        ##1 (!dev_clear || $past(dcl_cmd || sdc_cmd)))
        else $error("device clear pulse wrong");
    sdc_addr_a: assert property (sdc_cmd && !listen_reg |=> !dev_clear)
        else $error("selective clear while unaddressed");
    get_src_a: assert property (get_cmd |=> trig_out == $past(listen_reg && trig_bus_reg))
        else $error("trigger source gate wrong");
    spoll_byte_a: assert property (spe_cmd |=> spoll_active
        && spoll_byte[grlc_pkg::STB_MAV_BIT] == $past(mav_in))
        else $error("serial poll byte wrong");
endmodule

// *** sim/grlc_host_model.sv ***
// bus controller model: attention bytes, remote enable and interface clear
`timescale 1ns/10ps
module grlc_host_model (
    input wire logic ref_clk,
    output logic ifc_b,
    output logic ren_b,
    output logic cmd_valid,
    output logic [7:0] cmd_byte
);
    // 100 us at the 8 ns clock; shorter holds are not allowed on the bus
    localparam int IFC_HOLD = 12500;

    // lines idle high, no byte offered
    initial begin
        ifc_b = 1'b1;
        ren_b = 1'b1;
        cmd_valid = 1'b0;
        cmd_byte = 8'h5a;
    end

    // one attention byte for one cycle; the data lines do not keep it afterwards
    task automatic send_cmd(input logic [7:0] b);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_byte <= b;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        cmd_byte <= ~b;
    endtask

    // remote enable level, then let the synchroniser settle
    task automatic set_ren(input logic on);
        @(posedge ref_clk);
        ren_b <= ~on;
        repeat (4) @(posedge ref_clk);
    endtask

    // interface clear held for the full minimum time
    task automatic clear_bus();
        @(posedge ref_clk);
        ifc_b <= 1'b0;
        repeat (IFC_HOLD) @(posedge ref_clk);
        ifc_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule

// *** sim/grlc_top_bench.sv ***
// self-checking bench for the bus remote/local control block
`timescale 1ns/10ps
module grlc_top_bench;
    localparam logic [31:0] S_REM = 32'h1 << grlc_pkg::ST_REMOTE;
    localparam logic [31:0] S_LCK = 32'h1 << grlc_pkg::ST_LOCK;
    localparam logic [31:0] S_TLK = 32'h1 << grlc_pkg::ST_TALK;
    localparam logic [31:0] S_LIS = 32'h1 << grlc_pkg::ST_LISTEN;
    localparam logic [31:0] S_SPL = 32'h1 << grlc_pkg::ST_SPOLL;
    localparam logic [31:0] S_SRQ = 32'h1 << grlc_pkg::ST_SRQ;
    logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, mav_in, key_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] key_code, key_fwd_code;
    logic ifc_b, ren_b, cmd_valid, key_fwd_valid, talk_active, listen_active, remote_ind;
    logic lockout, spoll_active, srq_out, dev_clear, trig_out, display_restore;
    logic [7:0] cmd_byte, spoll_byte, pv;
    logic [32:0] rd_q[$];
    logic [32:0] rd_exp;
    logic [7:0] pl_q[$];
    int num_errors, checks_done;
    logic [4:0] my_a, oth;
    logic [7:0] rv;

    grlc_top u_grlc_top (.ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ifc_b(ifc_b), .ren_b(ren_b),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .mav_in(mav_in), .key_valid(key_valid),
        .key_code(key_code), .key_fwd_valid(key_fwd_valid), .key_fwd_code(key_fwd_code),
        .talk_active(talk_active), .listen_active(listen_active), .remote_ind(remote_ind),
        .lockout(lockout), .spoll_active(spoll_active), .spoll_byte(spoll_byte),
        .srq_out(srq_out), .dev_clear(dev_clear), .trig_out(trig_out),
        .display_restore(display_restore));
    grlc_host_model u_grlc_host_model (.ref_clk(ref_clk), .ifc_b(ifc_b), .ren_b(ren_b),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; the expected answer is queued for the monitor
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic err, input logic [31:0] exp);
        int n;
        rd_q.push_back({err, w ? 32'h0 : exp});
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0, exp);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 32'h0);
    endtask

    // attention byte; a nonzero note is the pulse pattern it should cause
    task automatic cmd(input logic [7:0] b, input logic [7:0] exp);
        if (exp != 8'h00) pl_q.push_back(exp);
        u_grlc_host_model.send_cmd(b);
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic press(input logic [3:0] k, input logic [7:0] exp);
        if (exp != 8'h00) pl_q.push_back(exp);
        @(posedge ref_clk);
        key_valid <= 1'b1;
        key_code <= k;
        @(posedge ref_clk);
        key_valid <= 1'b0;
        key_code <= 4'($urandom);
        repeat (2) @(posedge ref_clk);
    endtask

    function automatic logic [7:0] la(input logic [4:0] a);
        la = {1'b0, grlc_pkg::GRP_LISTEN, a};
    endfunction

    function automatic logic [7:0] ta(input logic [4:0] a);
        ta = {1'b0, grlc_pkg::GRP_TALK, a};
    endfunction

    function automatic logic [31:0] ctrl_v(input logic t, input logic [4:0] a);
        ctrl_v = ({31'h0, t} << grlc_pkg::CTRL_TRIG_BIT) | {27'h0, a};
    endfunction

    // completed transfers: unexpected ones compare against unknown and fail;
    // a status read also holds the level ports against the same expected bits
    always @(posedge ref_clk) begin
        if (psel && penable && pready) begin
            rd_exp = (rd_q.size() > 0) ? rd_q.pop_front() : 33'hx;
            check({31'h0, pslverr, pwrite ? 32'h0 : prdata}, {31'h0, rd_exp});
            if (!pwrite && paddr == grlc_pkg::OFF_STATUS) begin
                check({58'h0, srq_out, spoll_active, listen_active, talk_active,
                    lockout, remote_ind}, {58'h0, rd_exp[5:0]});
            end
        end
    end

    // pulse outputs: each one must match the oldest note
    assign pv = {dev_clear, trig_out, display_restore, key_fwd_valid,
        key_fwd_valid ? key_fwd_code : 4'h0};
    always @(posedge ref_clk) begin
        if (rst_b === 1'b1 && pv !== 8'h00) begin
            check({56'h0, pv}, {56'h0, (pl_q.size() > 0) ? pl_q.pop_front() : 8'hx});
        end
    end

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        mav_in = 1'b0;
        key_valid = 1'b0;
        key_code = 4'h0;
        num_errors = 0;
        checks_done = 0;
        void'($urandom(63018));
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        my_a = 5'($urandom_range(30, 0));
        oth = (my_a == 5'h1e) ? 5'h00 : my_a + 5'h01;
        rv = 8'($urandom) & 8'haf;
        // reset values, unmapped place, address limits
        rd(grlc_pkg::OFF_CTRL, ctrl_v(1'b0, grlc_pkg::ADDR_RESET));
        rd(grlc_pkg::OFF_SRE, 32'h0);
        rd(grlc_pkg::OFF_STATUS, 32'h0);
        apb(1'b0, 12'h010, 32'h0, 1'b1, 32'h0);
        wr(grlc_pkg::OFF_CTRL, 32'h1f);
        rd(grlc_pkg::OFF_CTRL, ctrl_v(1'b0, grlc_pkg::ADDR_RESET));
        wr(grlc_pkg::OFF_CTRL, {27'h0, grlc_pkg::ADDR_MAX});
        rd(grlc_pkg::OFF_CTRL, ctrl_v(1'b0, grlc_pkg::ADDR_MAX));
        wr(grlc_pkg::OFF_CTRL, {27'h0, my_a});
        // addressing in local state
        cmd(la(oth), 8'h00);
        cmd(ta(oth), 8'h00);
        rd(grlc_pkg::OFF_STATUS, 32'h0);
        cmd(ta(my_a), 8'h00);
        rd(grlc_pkg::OFF_STATUS, S_TLK);
        cmd(ta(oth), 8'h00);
        // remote enable alone, then listen addressed
        u_grlc_host_model.set_ren(1'b1);
        rd(grlc_pkg::OFF_STATUS, 32'h0);
        cmd(la(my_a), 8'h00);
        rd(grlc_pkg::OFF_STATUS, S_REM | S_LIS);
        check({63'h0, remote_ind}, 64'h1);
        cmd(la(grlc_pkg::ADDR_UNADDR), 8'h00);
        cmd(ta(my_a), 8'h00);
        rd(grlc_pkg::OFF_STATUS, S_REM | S_TLK);
        cmd(ta(grlc_pkg::ADDR_UNADDR), 8'h00);
        // front panel while remote
        press(4'h2, 8'h00);
        press(grlc_pkg::KEY_POWER, 8'h10);
        press(grlc_pkg::KEY_LOCAL, 8'h20);
        rd(grlc_pkg::OFF_STATUS, 32'h0);
        check({63'h0, remote_ind}, 64'h0);
        // lockout, then go-to-local
        cmd(la(my_a), 8'h00);
        cmd({1'b0, grlc_pkg::CMD_LLO}, 8'h00);
        press(grlc_pkg::KEY_LOCAL, 8'h00);
        press(4'h3, 8'h00);
        press(grlc_pkg::KEY_POWER, 8'h10);
        rd(grlc_pkg::OFF_STATUS, S_REM | S_LIS | S_LCK);
        cmd({1'b0, grlc_pkg::CMD_GTL}, 8'h00);
        press(4'h3, 8'h13);
        rd(grlc_pkg::OFF_STATUS, S_LIS);
        // device clears, addressed and not
        u_grlc_host_model.set_ren(1'b0);
        cmd({1'b0, grlc_pkg::CMD_SDC}, 8'h80);
        cmd(la(grlc_pkg::ADDR_UNADDR), 8'h00);
        cmd({1'b0, grlc_pkg::CMD_SDC}, 8'h00);
        cmd({1'b0, grlc_pkg::CMD_DCL}, 8'h80);
        // group trigger against the trigger source
        cmd(la(my_a), 8'h00);
        cmd({1'b0, grlc_pkg::CMD_GET}, 8'h00);
        wr(grlc_pkg::OFF_CTRL, ctrl_v(1'b1, my_a));
        cmd({1'b0, grlc_pkg::CMD_GET}, 8'h40);
        cmd(la(grlc_pkg::ADDR_UNADDR), 8'h00);
        cmd({1'b0, grlc_pkg::CMD_GET}, 8'h00);
        // service request and serial poll
        wr(grlc_pkg::OFF_STB, {24'h0, rv});
        wr(grlc_pkg::OFF_SRE, 32'h10);
        rd(grlc_pkg::OFF_STATUS, 32'h0);
        @(posedge ref_clk);
        mav_in <= 1'b1;
        rd(grlc_pkg::OFF_STATUS, S_SRQ);
        rd(grlc_pkg::OFF_STB, {24'h0, rv | 8'h50});
        cmd({1'b0, grlc_pkg::CMD_SPE}, 8'h00);
        check({56'h0, spoll_byte}, {56'h0, rv | 8'h50});
        rd(grlc_pkg::OFF_STATUS, S_SRQ | S_SPL);
        cmd({1'b0, grlc_pkg::CMD_SPD}, 8'h00);
        wr(grlc_pkg::OFF_SRE, 32'h0);
        rd(grlc_pkg::OFF_STATUS, 32'h0);
        // interface clear keeps the settings
        cmd(la(my_a), 8'h00);
        rd(grlc_pkg::OFF_STATUS, S_LIS);
        u_grlc_host_model.clear_bus();
        rd(grlc_pkg::OFF_STATUS, 32'h0);
        rd(grlc_pkg::OFF_CTRL, ctrl_v(1'b1, my_a));
        rd(grlc_pkg::OFF_STB, {24'h0, rv | 8'h10});
        repeat (2) @(posedge ref_clk);
        check(64'(rd_q.size()), 64'h0);
        check(64'(pl_q.size()), 64'h0);
        report_and_stop();
    end
endmodule
